/* rtl/otalrt_core.sv */
`timescale 1ns/10ps
`default_nettype none
`include "otalrt_map.svh"
module otalrt_core (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Conversion results
  input wire logic I_RESULT_VALID,
  input wire logic signed [15:0] I_RESULT,
  // Configuration
  input wire logic signed [15:0] I_TRIP_LIMIT_VALUE,
  input wire logic signed [15:0] I_HYSTERESIS_LIMIT_VALUE,
  input wire logic [1:0] I_FAULT_QUEUE,
  input wire logic I_POLARITY_HIGH,
  input wire logic I_INTERRUPT_MODE,
  input wire logic I_BUS_ALERT_MODE,
  input wire logic I_SHUTDOWN,
  // Bus events
  input wire logic I_REG_READ,
  // Alert pin, open drain
  output logic O_OVERTEMP_ALERT_PIN_O,
  output logic O_OVERTEMP_ALERT_PIN_OE,
  // Status
  output logic O_ALERT_ACTIVE,
  output logic [1:0] O_MODE
);
  function automatic logic [2:0] otalrt_fault_need(input logic [1:0] code);
    case (code)
      `OTALRT_FQ_1: otalrt_fault_need = `OTALRT_CNT_1;
      `OTALRT_FQ_2: otalrt_fault_need = `OTALRT_CNT_2;
      `OTALRT_FQ_4: otalrt_fault_need = `OTALRT_CNT_4;
      default: otalrt_fault_need = `OTALRT_CNT_6;
    endcase
  endfunction : otalrt_fault_need

  otalrt_pkg::otalrt_mode_t mode;
  logic trip_hit;
  logic below_hyst;
  logic [2:0] fault_need;
  logic [2:0] fault_q;
  logic [2:0] fault_d;
  logic level_q;
  logic intr_q;
  logic active_d;
  logic meas_ok;
  logic pin_oe_d;
  // Registered pin and status, so a configuration change cannot glitch the pin
  logic active_q;
  logic pin_oe_q;
  otalrt_pkg::otalrt_mode_t mode_q;

  always_comb begin
    if (I_BUS_ALERT_MODE) begin
      mode = otalrt_pkg::OTALRT_BUSALERT;
    end else if (I_INTERRUPT_MODE) begin
      mode = otalrt_pkg::OTALRT_INTR;
    end else begin
      mode = otalrt_pkg::OTALRT_LEVEL;
    end
  end

  assign meas_ok = I_RESULT_VALID && !I_SHUTDOWN;
  assign trip_hit = I_RESULT >= I_TRIP_LIMIT_VALUE;
  assign below_hyst = I_RESULT < I_HYSTERESIS_LIMIT_VALUE;
  assign fault_need = otalrt_fault_need(I_FAULT_QUEUE);

  // Saturating consecutive-trip counter
  always_comb begin
    fault_d = fault_q;
    if (meas_ok) begin
      if (!trip_hit) begin
        fault_d = 3'h0;
      end else if (fault_q < `OTALRT_CNT_6) begin
        fault_d = fault_q + 3'h1;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      fault_q <= `OTALRT_FAULT_RST;
    end else begin
      fault_q <= fault_d;
    end
  end

  // Counter steps once per trip result until it reaches 6, and freezes while no result is taken
  a_fault_step: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (meas_ok && trip_hit && fault_q < `OTALRT_CNT_6) |=> fault_q == $past(fault_q) + 3'h1)
    else $error("fault counter did not step");
  a_shut_count: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    $past(I_SHUTDOWN) |-> $stable(fault_q))
    else $error("fault counter moved in shutdown");

  // Level behaviour state; frozen while no result arrives, e.g. in shutdown
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      level_q <= `OTALRT_ALERT_RST;
    end else if (meas_ok) begin
      if (trip_hit) begin
        level_q <= 1'b1;
      end else if (below_hyst) begin
        level_q <= 1'b0;
      end
    end
  end

  // Level state moves only on a qualifying result
  a_level_keep: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (level_q && !(meas_ok && !trip_hit && below_hyst)) |=> level_q)
    else $error("level alert cleared above hysteresis");
  a_level_off: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (!level_q && !(meas_ok && trip_hit)) |=> !level_q)
    else $error("level alert set without trip");

  // Latched interrupt; a new qualifying result wins over a read
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      intr_q <= `OTALRT_ALERT_RST;
    end else if (mode != otalrt_pkg::OTALRT_INTR) begin
      intr_q <= 1'b0;
    end else if (meas_ok && trip_hit && (fault_d >= fault_need)) begin
      intr_q <= 1'b1;
    end else if (I_REG_READ) begin
      intr_q <= 1'b0;
    end
  end

  // Latch holds until a read, sets only once the count is met
  a_intr_hold: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (mode == otalrt_pkg::OTALRT_INTR && intr_q && !I_REG_READ) |=> intr_q)
    else $error("interrupt dropped without read");
  a_intr_early: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (mode == otalrt_pkg::OTALRT_INTR && !intr_q && meas_ok && trip_hit &&
    fault_d < fault_need) |=> !intr_q)
    else $error("interrupt set before fault count");
  a_intr_set: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (mode == otalrt_pkg::OTALRT_INTR && meas_ok && trip_hit &&
    fault_d >= fault_need) |=> intr_q)
    else $error("interrupt not set at fault count");
  a_intr_zero: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (mode != otalrt_pkg::OTALRT_INTR) |=> !intr_q)
    else $error("interrupt latched outside interrupt mode");

  always_comb begin
    case (mode)
      otalrt_pkg::OTALRT_LEVEL: active_d = level_q;
      otalrt_pkg::OTALRT_INTR: active_d = intr_q;
      default: active_d = 1'b0;
    endcase
  end

  // Open drain: pull low when the electrical level must be low
  assign pin_oe_d = I_POLARITY_HIGH ? !active_d : active_d;

  // Reset releases the pin, which is the idle level of the default polarity
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      active_q <= `OTALRT_ALERT_RST;
      pin_oe_q <= `OTALRT_POL_RST;
    end else begin
      active_q <= active_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      mode_q <= otalrt_pkg::OTALRT_LEVEL;
    end else begin
      mode_q <= mode;
    end
  end

  assign O_OVERTEMP_ALERT_PIN_O = 1'b0;
  assign O_OVERTEMP_ALERT_PIN_OE = pin_oe_q;
  assign O_ALERT_ACTIVE = active_q;
  assign O_MODE = mode_q;

  // Outputs follow the state one cycle later
  a_out_track: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    O_ALERT_ACTIVE == $past(active_d))
    else $error("alert output does not follow state");
  a_busalrt_idle: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (mode == otalrt_pkg::OTALRT_BUSALERT) |=> !O_ALERT_ACTIVE)
    else $error("alert active in bus-alert mode");
  a_intr_decode: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (I_INTERRUPT_MODE && !I_BUS_ALERT_MODE) |=> O_MODE == 2'(otalrt_pkg::OTALRT_INTR))
    else $error("interrupt mode decode wrong");
  a_mode_bus: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    I_BUS_ALERT_MODE |=> O_MODE == 2'(otalrt_pkg::OTALRT_BUSALERT))
    else $error("bus-alert mode decode wrong");

  // Checks across the whole block
  a_level_trip: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (mode == otalrt_pkg::OTALRT_LEVEL && meas_ok && trip_hit) |=> level_q)
    else $error("level alert not set on trip");
  a_level_hyst: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (mode == otalrt_pkg::OTALRT_LEVEL && $fell(level_q)) |-> $past(below_hyst && meas_ok))
    else $error("level alert cleared without hysteresis");
  a_shut_hold: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    $past(I_SHUTDOWN) |-> $stable(level_q))
    else $error("level alert changed in shutdown");
  a_intr_count: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    $rose(intr_q) |-> $past(fault_d) >= $past(fault_need))
    else $error("interrupt before fault count");
  a_intr_clear: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (intr_q && I_REG_READ && !(meas_ok && trip_hit)) |=> !intr_q)
    else $error("read did not clear interrupt");
  a_intr_rearm: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    $rose(intr_q) |-> $past(meas_ok && trip_hit))
    else $error("interrupt without trip result");
  a_fault_zero: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (meas_ok && !trip_hit) |=> fault_q == 3'h0)
    else $error("fault counter not zeroed");
  a_pin_polar: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    !$past(I_SYS_RST) |->
    O_OVERTEMP_ALERT_PIN_OE == (O_ALERT_ACTIVE ^ $past(I_POLARITY_HIGH)))
    else $error("pin polarity wrong");
  a_reset_level: assert property (@(posedge I_CLK) disable iff (I_SYS_RST)
    (!I_INTERRUPT_MODE && !I_BUS_ALERT_MODE) |=> O_MODE == 2'(otalrt_pkg::OTALRT_LEVEL))
    else $error("mode decode wrong");
endmodule : otalrt_core
`default_nettype wire

/* common/otalrt_map.svh */
// What this block does
// - Alert pin starts in over-temperature mode, not bus-alert mode, after reset.
// - Configuration chooses over-temperature behaviour, or bus-alert mode, in which the alert stays inactive and the pin stays at its idle level.
// - Level behaviour after reset; latched interrupt only when configured.
// - Level behaviour: alert goes active when result is at or above trip limit.
// - Level behaviour: alert clears only when result is strictly below hysteresis limit.
// - Shutdown leaves the level-behaviour alert state untouched.
// - Interrupt behaviour: assert only after configured count of consecutive trip results.
// - Interrupt behaviour: a register read clears the latched alert unless a qualifying trip result arrives in the same cycle.
// - After a clear, reassert on the next trip result once the consecutive count meets the fault count; a read does not reset that count.
// - Two-bit field selects 1, 2, 4 or 6 faults; 1 by default.
// - Polarity bit: cleared means active low (default), set means active high.
// - Mode bit: cleared selects level behaviour (default), set selects interrupt.
// - Limits are 16-bit signed values compared as signed numbers.
`ifndef OTALRT_MAP_SVH
`define OTALRT_MAP_SVH
`define OTALRT_TEMP_W 16
`define OTALRT_FQ_1 2'h0
`define OTALRT_FQ_2 2'h1
`define OTALRT_FQ_4 2'h2
`define OTALRT_FQ_6 2'h3
`define OTALRT_CNT_1 3'h1
`define OTALRT_CNT_2 3'h2
`define OTALRT_CNT_4 3'h4
`define OTALRT_CNT_6 3'h6
`define OTALRT_FQ_RST 2'h0
`define OTALRT_POL_RST 1'h0
`define OTALRT_INT_RST 1'h0
`define OTALRT_BUSALRT_RST 1'h0
`define OTALRT_FAULT_RST 3'h0
`define OTALRT_ALERT_RST 1'h0
`endif

/* common/otalrt_pkg.sv */
package otalrt_pkg;
  typedef enum logic [1:0] {
    OTALRT_LEVEL,
    OTALRT_INTR,
    OTALRT_BUSALERT
  } otalrt_mode_t;
endpackage : otalrt_pkg

/* test/otalrt_host.sv */
`timescale 1ns/10ps
`default_nettype none
module otalrt_host (
  // Bus side
  input wire logic i_clk,
  input wire logic i_rd_req,
  output logic o_reg_read,
  // Alert line
  input wire logic i_oe,
  input wire logic i_o,
  output logic o_pin
);
  // Pull-up holds the line high unless the device drives it
  assign o_pin = i_oe ? i_o : 1'b1;
  // One read pulse per request; the read is what clears a latched alert
  always_ff @(posedge i_clk) o_reg_read <= i_rd_req;
endmodule : otalrt_host
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 0, rst = 1, vld = 0, intm = 0, pol = 0, bam = 0, sd = 0, rdq = 0;
  logic rd, pin, pin_o, oe, act;
  logic signed [15:0] res = 16'h0000, trip = 16'hFFFB, hyst = 16'hFFF6;
  logic [1:0] fq = 2'h0, mode;
  int err_count = 0, checks = 0, cyc = 0;
  int need[4] = '{1, 2, 4, 6};
  always #5 clk = ~clk;
  otalrt_core dut_u (.I_CLK(clk), .I_SYS_RST(rst), .I_RESULT_VALID(vld), .I_RESULT(res),
    .I_TRIP_LIMIT_VALUE(trip), .I_HYSTERESIS_LIMIT_VALUE(hyst), .I_FAULT_QUEUE(fq),
    .I_POLARITY_HIGH(pol), .I_INTERRUPT_MODE(intm), .I_BUS_ALERT_MODE(bam),
    .I_SHUTDOWN(sd), .I_REG_READ(rd), .O_OVERTEMP_ALERT_PIN_O(pin_o),
    .O_OVERTEMP_ALERT_PIN_OE(oe), .O_ALERT_ACTIVE(act), .O_MODE(mode));
  otalrt_host host_u (.i_clk(clk), .i_rd_req(rdq), .o_reg_read(rd), .i_oe(oe), .i_o(pin_o),
    .o_pin(pin));
  task automatic chk(input string n, input logic [1:0] e, input logic [1:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic pchk(input logic e);
    chk("alert", {1'b0, e}, {1'b0, act});
    chk("pin", {1'b0, pol ? e : !e}, {1'b0, pin});
  endtask : pchk
  task automatic feed(input logic signed [15:0] v);
    @(posedge clk);
    vld <= 1'b1;
    res <= v;
    @(posedge clk);
    vld <= 1'b0;
    @(posedge clk);
    #1;
  endtask : feed
  task automatic rdpulse;
    @(posedge clk) rdq <= 1'b1;
    @(posedge clk) rdq <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : rdpulse
  task automatic t_level;
    feed(16'hFFFA); pchk(1'b0);
    feed(16'hFFFB); pchk(1'b1);
    feed(16'hFFF6); pchk(1'b1);
    @(posedge clk) sd <= 1'b1;
    feed(16'h8000); pchk(1'b1);
    @(posedge clk) sd <= 1'b0;
    feed(16'hFFF5); pchk(1'b0);
    feed(16'h7FFF); pchk(1'b1);
    feed(16'h8000); pchk(1'b0);
  endtask : t_level
  task automatic t_intr;
    @(posedge clk) intm <= 1'b1;
    @(posedge clk);
    #1 chk("mode", 2'h1, mode);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) fq <= 2'(i);
      repeat (need[i] - 1) feed(16'h0000);
      feed(16'hFFF0); pchk(1'b0);
      repeat (need[i] - 1) feed(16'h0000);
      pchk(1'b0);
      feed(16'h0000); pchk(1'b1);
      rdpulse(); pchk(1'b0);
      feed(16'hFFF0); pchk(1'b0);
      repeat (need[i] - 1) feed(16'h0000);
      pchk(1'b0);
      feed(16'hFFF0); pchk(1'b0);
    end
  endtask : t_intr
  task automatic t_pol;
    @(posedge clk) begin
      intm <= 1'b0;
      pol <= 1'b1;
      bam <= 1'b1;
    end
    @(posedge clk);
    #1 chk("mode", 2'h2, mode);
    pchk(1'b0);
    @(posedge clk) bam <= 1'b0;
    feed(16'h0000); pchk(1'b1);
  endtask : t_pol
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      $display("[ERR] cycles expected below %0d seen %0d", 3000, cyc);
      stop_test();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk("mode", 2'h0, mode);
    pchk(1'b0);
    t_level();
    t_intr();
    t_pol();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
